//--- atc2_pkg.sv
// Shared constants and types for the converter's second configuration block.
package atc2_pkg;

    // Register byte offsets on the peripheral bus.
    localparam int unsigned     ADDR_W           = 12;
    localparam logic [11:0]     OFS_CONFIG_ONE   = 12'h000;
    localparam logic [11:0]     OFS_CONFIG_TWO   = 12'h004;
    localparam logic [11:0]     OFS_CONTROL      = 12'h008;
    localparam logic [11:0]     OFS_STATUS       = 12'h00C;
    localparam logic [31:0]     RESET_WORD       = 32'h0000_0000;

    // Field positions in config_one.
    localparam int unsigned     C1_LSMP_BIT      = 4;
    localparam int unsigned     C1_ICLK_LSB      = 0;

    // Field positions in config_two.
    localparam int unsigned     C2_SET_BIT       = 4;
    localparam int unsigned     C2_FORCE_BIT     = 3;
    localparam int unsigned     C2_HSC_BIT       = 2;
    localparam int unsigned     C2_EXT_LSB       = 0;

    // Field positions in control and status.
    localparam int unsigned     CT_START_BIT     = 0;
    localparam int unsigned     CT_CONT_BIT      = 1;
    localparam int unsigned     CT_ABORT_BIT     = 2;
    localparam int unsigned     ST_BUSY_BIT      = 0;
    localparam int unsigned     ST_SAMPLE_BIT    = 1;
    localparam int unsigned     ST_ARUN_BIT      = 2;
    localparam int unsigned     ST_ARDY_BIT      = 3;
    localparam int unsigned     ST_DONE_BIT      = 4;

    // Sample and conversion phase lengths, in conversion-clock cycles.
    localparam logic [7:0]      SAMPLE_BASE      = 8'h04;
    localparam logic [7:0]      EXTRA_CODE0      = 8'h14;
    localparam logic [7:0]      EXTRA_CODE1      = 8'h0C;
    localparam logic [7:0]      EXTRA_CODE2      = 8'h06;
    localparam logic [7:0]      EXTRA_CODE3      = 8'h02;
    localparam logic [7:0]      HSC_EXTRA        = 8'h02;

    // Conversion clock sources.
    typedef enum logic [1:0] {
        ICLK_BUS      = 2'h0,
        ICLK_BUS_DIV2 = 2'h1,
        ICLK_ALT      = 2'h2,
        ICLK_ASYNC    = 2'h3
    } atc2_iclk_t;

    // Conversion sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h1,
        ST_SAMPLE  = 3'h2,
        ST_CONVERT = 3'h4
    } atc2_state_t;

endpackage

//--- atc2_async_osc.sv
// Asynchronous conversion clock source with startup delay.
`timescale 1ns/1ps
`default_nettype none
module atc2_async_osc #(
    parameter int unsigned STARTUP_CYCLES = 8,
    parameter int unsigned HALF_CYCLES    = 2
) (
    // Clock and reset.
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  ce,
    // Control.
    input  wire logic  run,
    // Clock outputs.
    output logic       level,
    output logic       tick,
    output logic       ready
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        ready;
        logic        level;
        logic        tick;
    } atc2_osc_t;

    atc2_osc_t r;
    atc2_osc_t nxt;

    always_comb
    begin
        nxt = r;
        nxt.tick = 1'b0;
        if (!run)
        begin
            // A stopped source pays the startup delay again next time.
            nxt = '0;
        end
        else if (!r.ready)
        begin
            if (r.cnt == 16'(STARTUP_CYCLES - 1))
            begin
                nxt.ready = 1'b1;
                nxt.cnt = '0;
            end
            else
                nxt.cnt = r.cnt + 16'h0001;
        end
        else if (r.cnt == 16'(HALF_CYCLES - 1))
        begin
            nxt.cnt = '0;
            nxt.level = ~r.level;
            nxt.tick = ~r.level;
        end
        else
            nxt.cnt = r.cnt + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else if (ce)
            r <= nxt;
    end

    assign level = r.level;
    assign tick  = r.tick;
    assign ready = r.ready;
endmodule
`default_nettype wire

//--- atc2_tick_gen.sv
// Conversion clock enable generator for the selected input clock.
`timescale 1ns/1ps
`default_nettype none
module atc2_tick_gen (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // Source selection.
    input  wire logic [1:0]  sel,
    input  wire logic        enable,
    input  wire logic        alt_clock_in,
    input  wire logic        async_tick,
    // Conversion clock enable.
    output logic             tick
);
    typedef struct packed {
        logic alt_s1;
        logic alt_s2;
        logic alt_prev;
        logic div;
        logic tick;
    } atc2_tick_t;

    atc2_tick_t r;
    atc2_tick_t nxt;

    always_comb
    begin
        nxt = r;
        nxt.alt_s1 = alt_clock_in;
        nxt.alt_s2 = r.alt_s1;
        nxt.alt_prev = r.alt_s2;
        nxt.div = enable & ~r.div;
        unique case (atc2_pkg::atc2_iclk_t'(sel))
            atc2_pkg::ICLK_BUS:      nxt.tick = enable;
            atc2_pkg::ICLK_BUS_DIV2: nxt.tick = enable & r.div;
            atc2_pkg::ICLK_ALT:      nxt.tick = enable & r.alt_s2 & ~r.alt_prev;
            atc2_pkg::ICLK_ASYNC:    nxt.tick = enable & async_tick;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else if (ce)
            r <= nxt;
    end

    assign tick = r.tick;
endmodule
`default_nettype wire

//--- atc2_top.sv
// Second configuration register with its conversion timing sequencer.
//
// Functional notes
// - Bits 31..5 of config_two read zero; writes there are ignored.
// - Bit 4 selects channel set a (0) or channel set b (1).
// - Force bit 3 keeps async clock running and exported always.
// - Force clear: no clock output; async runs only when converting from it.
// - Forced async clock stays usable while idle or on another source.
// - Forced running clock lets conversion start without startup delay.
// - High-speed bit 2 adds 2 conversion-clock cycles per conversion.
// - Extension field applies only with long sample mode, else short.
// - Code 00 adds 20 cycles, sampling 24 cycles in total.
// - Code 01 adds 12 cycles, sampling 16 cycles in total.
// - Code 10 adds 6 (total 10); code 11 adds 2 (total 6).
// - Unforced async source starts at conversion, stops at end.
// - Conversion clock: bus, bus/2, alternate input, or async source.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module atc2_top #(
    parameter int unsigned CONV_CYCLES   = 16,
    parameter int unsigned ASYNC_STARTUP = 8,
    parameter int unsigned ASYNC_HALF    = 2
) (
    // Clock, reset and enable.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Alternate clock pin.
    input  wire logic        alt_clock_in,
    // Converter side.
    output logic             alt_channel_set_select,
    output logic             async_clock_out,
    output logic             conversion_active,
    output logic             sample_active,
    output logic             conversion_done
);
    typedef struct packed {
        logic                   long_sample_mode;
        logic [1:0]             input_clock_select;
        logic                   set_sel;
        logic                   force_en;
        logic                   hsc;
        logic [1:0]             ext_sel;
        logic                   continuous;
        atc2_pkg::atc2_state_t  state;
        logic [7:0]             cnt;
        logic                   lat_set;
        logic                   lat_hsc;
        logic                   lat_long;
        logic [1:0]             lat_ext;
        logic [1:0]             lat_iclk;
        logic                   done_flag;
        logic                   done_pulse;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
        logic                   async_out;
        logic                   active;
        logic                   sampling;
    } atc2_top_t;

    atc2_top_t r;
    atc2_top_t nxt;

    logic        busy;
    logic        async_run;
    logic        async_level;
    logic        async_tick;
    logic        async_ready;
    logic        ctick;
    logic [31:0] rd;
    logic        hit;
    logic        setup;
    logic        wr;
    logic        start;
    logic        abort;
    logic        done_evt;
    logic        done_clr;
    logic [7:0]  samp_len;
    logic [7:0]  conv_len;

    // Sample length in conversion-clock cycles for one setting.
    function automatic logic [7:0] sample_cycles(
        input logic       lng,
        input logic [1:0] ext
    );
        logic [7:0] extra;
        extra = atc2_pkg::EXTRA_CODE0;
        unique case (ext)
            2'h0: extra = atc2_pkg::EXTRA_CODE0;
            2'h1: extra = atc2_pkg::EXTRA_CODE1;
            2'h2: extra = atc2_pkg::EXTRA_CODE2;
            2'h3: extra = atc2_pkg::EXTRA_CODE3;
        endcase
        return lng ? atc2_pkg::SAMPLE_BASE + extra : atc2_pkg::SAMPLE_BASE;
    endfunction

    assign busy = (r.state != atc2_pkg::ST_IDLE);

    assign async_run = r.force_en |
        (busy & (r.lat_iclk == atc2_pkg::ICLK_ASYNC));

    atc2_async_osc #(
        .STARTUP_CYCLES (ASYNC_STARTUP),
        .HALF_CYCLES    (ASYNC_HALF)
    ) u_osc (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (async_run),
        .level   (async_level),
        .tick    (async_tick),
        .ready   (async_ready)
    );

    // ticks flow at once when the source already runs
    atc2_tick_gen u_tick (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .sel          (r.lat_iclk),
        .enable       (busy),
        .alt_clock_in (alt_clock_in),
        .async_tick   (async_tick),
        .tick         (ctick)
    );

    always_comb
    begin
        nxt = r;
        rd = '0;
        setup = psel & ~penable;
        hit = (paddr[1:0] == 2'h0) &&
              ((paddr == atc2_pkg::OFS_CONFIG_ONE) ||
               (paddr == atc2_pkg::OFS_CONFIG_TWO) ||
               (paddr == atc2_pkg::OFS_CONTROL) ||
               (paddr == atc2_pkg::OFS_STATUS));
        wr = psel & penable & r.pready & pwrite & ~r.pslverr & pstrb[0];

        // Read data is captured in the setup cycle.
        unique case (paddr)
            atc2_pkg::OFS_CONFIG_ONE:
            begin
                rd[atc2_pkg::C1_LSMP_BIT] = r.long_sample_mode;
                rd[atc2_pkg::C1_ICLK_LSB +: 2] = r.input_clock_select;
            end
            atc2_pkg::OFS_CONFIG_TWO:
            begin
                rd[atc2_pkg::C2_SET_BIT] = r.set_sel;
                rd[atc2_pkg::C2_FORCE_BIT] = r.force_en;
                rd[atc2_pkg::C2_HSC_BIT] = r.hsc;
                rd[atc2_pkg::C2_EXT_LSB +: 2] = r.ext_sel;
            end
            atc2_pkg::OFS_CONTROL:
            begin
                rd[atc2_pkg::CT_CONT_BIT] = r.continuous;
            end
            atc2_pkg::OFS_STATUS:
            begin
                rd[atc2_pkg::ST_BUSY_BIT] = busy;
                rd[atc2_pkg::ST_SAMPLE_BIT] = (r.state == atc2_pkg::ST_SAMPLE);
                rd[atc2_pkg::ST_ARUN_BIT] = async_run;
                rd[atc2_pkg::ST_ARDY_BIT] = async_ready;
                rd[atc2_pkg::ST_DONE_BIT] = r.done_flag;
            end
            default: rd = '0;
        endcase

        nxt.pready = setup;
        nxt.pslverr = setup & ~hit;
        nxt.prdata = (setup & hit & ~pwrite) ? rd : '0;

        start = 1'b0;
        abort = 1'b0;
        done_clr = 1'b0;
        if (wr)
        begin
            unique case (paddr)
                atc2_pkg::OFS_CONFIG_ONE:
                begin
                    nxt.long_sample_mode = pwdata[atc2_pkg::C1_LSMP_BIT];
                    nxt.input_clock_select =
                        pwdata[atc2_pkg::C1_ICLK_LSB +: 2];
                end
                atc2_pkg::OFS_CONFIG_TWO:
                begin
                    nxt.set_sel = pwdata[atc2_pkg::C2_SET_BIT];
                    nxt.force_en = pwdata[atc2_pkg::C2_FORCE_BIT];
                    nxt.hsc = pwdata[atc2_pkg::C2_HSC_BIT];
                    nxt.ext_sel = pwdata[atc2_pkg::C2_EXT_LSB +: 2];
                end
                atc2_pkg::OFS_CONTROL:
                begin
                    nxt.continuous = pwdata[atc2_pkg::CT_CONT_BIT];
                    start = pwdata[atc2_pkg::CT_START_BIT];
                    abort = pwdata[atc2_pkg::CT_ABORT_BIT];
                end
                atc2_pkg::OFS_STATUS:
                begin
                    done_clr = pwdata[atc2_pkg::ST_DONE_BIT];
                end
                default: done_clr = 1'b0;
            endcase
        end

        samp_len = sample_cycles(r.lat_long, r.lat_ext);
        conv_len = 8'(CONV_CYCLES) +
            (r.lat_hsc ? atc2_pkg::HSC_EXTRA : 8'h00);

        done_evt = 1'b0;
        unique case (r.state)
            atc2_pkg::ST_IDLE:
            begin
                if (start && !abort)
                begin
                    nxt.state = atc2_pkg::ST_SAMPLE;
                    nxt.cnt = '0;
                end
            end
            atc2_pkg::ST_SAMPLE:
            begin
                if (ctick)
                begin
                    if (r.cnt == samp_len - 8'h01)
                    begin
                        nxt.state = atc2_pkg::ST_CONVERT;
                        nxt.cnt = '0;
                    end
                    else
                        nxt.cnt = r.cnt + 8'h01;
                end
            end
            atc2_pkg::ST_CONVERT:
            begin
                if (ctick)
                begin
                    if (r.cnt == conv_len - 8'h01)
                    begin
                        done_evt = 1'b1;
                        nxt.cnt = '0;
                        nxt.state = r.continuous ?
                            atc2_pkg::ST_SAMPLE : atc2_pkg::ST_IDLE;
                    end
                    else
                        nxt.cnt = r.cnt + 8'h01;
                end
            end
            default:
            begin
                nxt.state = atc2_pkg::ST_IDLE;
                nxt.cnt = '0;
            end
        endcase

        if (abort)
        begin
            nxt.state = atc2_pkg::ST_IDLE;
            nxt.cnt = '0;
        end

        // settings latched only when a conversion begins
        if (nxt.state == atc2_pkg::ST_SAMPLE && nxt.cnt == 8'h00 &&
            (r.state == atc2_pkg::ST_IDLE || done_evt))
        begin
            nxt.lat_set = r.set_sel;
            nxt.lat_hsc = r.hsc;
            nxt.lat_long = r.long_sample_mode;
            nxt.lat_ext = r.ext_sel;
            if (r.state == atc2_pkg::ST_IDLE)
                nxt.lat_iclk = r.input_clock_select;
        end

        // A completion in the clearing cycle keeps the flag set.
        nxt.done_flag = (r.done_flag & ~done_clr) | done_evt;
        nxt.done_pulse = done_evt;
        nxt.async_out = r.force_en & async_level;
        nxt.active = (nxt.state != atc2_pkg::ST_IDLE);
        nxt.sampling = (nxt.state == atc2_pkg::ST_SAMPLE);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.state <= atc2_pkg::ST_IDLE;
        end
        else if (ce)
            r <= nxt;
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign alt_channel_set_select = r.lat_set;
    assign async_clock_out = r.async_out;
    assign conversion_active = r.active;
    assign sample_active = r.sampling;
    assign conversion_done = r.done_pulse;
endmodule
`default_nettype wire

//--- atc2_monitor.sv
// Assertion checker for the second configuration register block.
`timescale 1ns/1ps
`default_nettype none
module atc2_monitor #(
    parameter int unsigned ASYNC_STARTUP = 8,
    parameter int unsigned ASYNC_HALF    = 2
) (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // APB.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Converter side.
    input wire logic        async_clock_out,
    input wire logic        conversion_active,
    input wire logic        sample_active,
    input wire logic        conversion_done
);
    localparam int LIMIT = ASYNC_STARTUP + 2 * ASYNC_HALF + 4;
    logic       force_reg;
    logic       last_reg;
    logic [7:0] still_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    // Tracks the force bit and how long the exported clock has not moved.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            force_reg <= 1'b0;
            last_reg  <= 1'b0;
            still_reg <= 8'h00;
        end
        else
        begin
            if (pready && pwrite && !pslverr && pstrb[0] && paddr == 12'h004)
                force_reg <= pwdata[3];
            last_reg  <= async_clock_out;
            still_reg <= (force_reg && async_clock_out == last_reg)
                       ? still_reg + 8'h01 : 8'h00;
        end
    end
    setup_ready_a: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    rsvd_zero_a:
        assert property (pready && !pwrite && paddr == 12'h004
                         |-> prdata[31:5] == 27'h0)
        else $error("reserved bits read nonzero");
    err_unmapped_a: assert property (setup_s ##0 paddr > 12'h00C |=> pslverr)
        else $error("unmapped access not refused");
    done_pulse_a: assert property (conversion_done |=> !conversion_done)
        else $error("done longer than one cycle");
    done_active_a: assert property (conversion_done |-> $past(conversion_active))
        else $error("done without conversion");
    sample_conv_a: assert property (sample_active |-> conversion_active)
        else $error("sampling outside conversion");
    start_sample_a: assert property ($rose(conversion_active) |-> sample_active)
        else $error("conversion not starting in sample phase");
    async_off_a: assert property ((!force_reg)[*2] |-> !async_clock_out)
        else $error("clock exported while force clear");
    async_runs_a: assert property (force_reg |-> still_reg < LIMIT)
        else $error("forced clock not running");
endmodule

bind atc2_top atc2_monitor #(
    .ASYNC_STARTUP(ASYNC_STARTUP),
    .ASYNC_HALF   (ASYNC_HALF)
) u_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .async_clock_out(async_clock_out), .conversion_active(conversion_active),
    .sample_active(sample_active), .conversion_done(conversion_done)
);
`default_nettype wire

//--- adc_timing_config_two_test.sv
// Self-checking bench for the second configuration register block.
`timescale 1ns/1ps
`default_nettype none
module adc_timing_config_two_test;
    logic        pclk, presetn, ce, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  pstrb, strb;
    logic [2:0]  alt_div;
    logic        pready, pslverr, alt_clock_in, set_sel, aclk_out;
    logic        conv_act, samp_act, conv_done;
    int          n_fail, tests_run, k, s_len, c_len, s_ref, c_ref, c_unf, hits;
    int          samp_tab [4] = '{24, 16, 10, 6};

    atc2_top #(.CONV_CYCLES(4), .ASYNC_STARTUP(6), .ASYNC_HALF(1)) dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alt_clock_in(alt_clock_in),
        .alt_channel_set_select(set_sel), .async_clock_out(aclk_out),
        .conversion_active(conv_act), .sample_active(samp_act),
        .conversion_done(conv_done)
    );

    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts sampling and busy cycles until the end-of-conversion pulse.
    task measure;
        int w;
        s_len = 0;
        c_len = 0;
        w = 0;
        while (conv_done !== 1'b1 && w < 2000)
        begin
            @(posedge pclk);
            w++;
            if (samp_act === 1'b1)
                s_len++;
            if (conv_act === 1'b1)
                c_len++;
        end
        check({31'h0, conv_done}, 32'h1);
    endtask

    task run_conv;
        apb(1'b1, 12'h008, 32'h1);
        measure();
    endtask

    task count_hi;
        hits = 0;
        repeat (40)
        begin
            @(posedge pclk);
            if (aclk_out === 1'b1)
                hits++;
        end
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        alt_div      <= alt_div + 3'h1;
        alt_clock_in <= alt_div[2];
    end

    initial
    begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        strb = 4'hF;
        alt_clock_in = 1'b0;
        alt_div = 3'h0;
        seed = 32'hea5e2231;
        n_fail = 0;
        tests_run = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 12'h004, 32'hFFFFFFFF);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h1F);
        for (k = 0; k < 6; k++)
        begin
            seed = lfsr(seed);
            apb(1'b1, 12'h004, seed);
            apb(1'b0, 12'h004, 32'h0);
            check(rd, seed & 32'h1F);
        end
        strb = 4'h0;
        apb(1'b1, 12'h004, 32'h0);
        strb = 4'hF;
        apb(1'b0, 12'h004, 32'h0);
        check(rd, seed & 32'h1F);
        apb(1'b0, 12'h010, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h006, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        run_conv();
        s_ref = s_len;
        c_ref = c_len;
        // Clock enable low freezes a running conversion for five cycles.
        apb(1'b1, 12'h008, 32'h1);
        ce <= 1'b0;
        repeat (5) @(posedge pclk);
        ce <= 1'b1;
        measure();
        check(c_len, c_ref);
        apb(1'b1, 12'h004, 32'h1);
        run_conv();
        check(s_len, s_ref);
        apb(1'b1, 12'h000, 32'h10);
        for (k = 0; k < 4; k++)
        begin
            apb(1'b1, 12'h004, k);
            run_conv();
            check(s_len - s_ref, samp_tab[k] - 4);
            check(c_len - s_len, c_ref - s_ref);
        end
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h4);
        run_conv();
        check(c_len - c_ref, 32'h2);
        apb(1'b1, 12'h000, 32'h10);
        apb(1'b1, 12'h004, 32'h10);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        check({set_sel, conv_act}, 32'h3);
        measure();
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge pclk);
        check({set_sel, conv_act}, 32'h1);
        measure();
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h008, 32'h4);
        repeat (2) @(posedge pclk);
        check({31'h0, conv_act}, 32'h0);
        for (k = 1; k < 4; k++)
        begin
            apb(1'b1, 12'h000, k);
            run_conv();
            check({31'h0, c_len > c_ref}, 32'h1);
        end
        // An unforced source is stopped again once the conversion ends.
        apb(1'b0, 12'h00C, 32'h0);
        check(rd & 32'hC, 32'h0);
        c_unf = c_len;
        apb(1'b1, 12'h004, 32'h8);
        repeat (20) @(posedge pclk);
        run_conv();
        check({31'h0, c_len < c_unf}, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        count_hi();
        check({31'h0, hits > 0 && hits < 40}, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        repeat (4) @(posedge pclk);
        count_hi();
        check(hits, 32'h0);
        // Continuous mode restarts at once and the done flag is sticky.
        apb(1'b1, 12'h008, 32'h3);
        measure();
        apb(1'b0, 12'h00C, 32'h0);
        check(rd & 32'h11, 32'h11);
        apb(1'b1, 12'h008, 32'h4);
        apb(1'b1, 12'h00C, 32'h10);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
